//--- link_partner_model.sv
// remote station model: sends link pulses on a set gap and reports descrambler lock
// assumes one clock domain and a one-cycle pulse per received link pulse
module link_partner_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic send_on,
    input wire logic [7:0] gap,
    input wire logic lock_on,
    output logic link_pulse,
    output logic descrambler_locked
);
    logic [7:0] count;

    // ----------------------------------------
    // pulse train, silent while switched off
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst || !send_on) begin
            count <= 8'h00;
            link_pulse <= 1'b0;
        end else if (count + 8'h01 >= gap) begin
            count <= 8'h00;
            link_pulse <= 1'b1;
        end else begin
            count <= count + 8'h01;
            link_pulse <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        descrambler_locked <= lock_on && !srst;
    end
endmodule : link_partner_model

//--- phy_link_and_jabber_monitor.sv
// link integrity and jabber monitor with latched status and interrupt registers
// assumes synchronous inputs, one-cycle link_pulse strobes and a simple register port
//
// Overview of operation
// - at 10 Mbit/s link bit reads 1 once link judged valid, 0 otherwise
// - over 100 ms without a pulse drops the link and clears the bit
// - without auto-negotiation, seven consecutive well-timed pulses restore the link
// - at 100 Mbit/s link needs descrambler lock held at least 330 us
// - with negotiation active, a link going invalid restarts negotiation
// - jabber bit always reads 0 at 100 Mbit/s
// - detected 10 Mbit/s jabber stays latched until status read or reset
// - at 10 Mbit/s, a transmission longer than 20 ms is a jabber
// - jabber blocks transmit, forces collision high, disables detection and half-duplex loopback
// - jabber persists 576 to 628 ms after transmit enable drops
// - link bit latched until status read, reset value 1
`include "phy_link_params.svh"

module phy_link_and_jabber_monitor #(
    parameter int unsigned LINK_MIN_CYC = `LINK_MIN_CYC,
    parameter int unsigned LINK_MAX_CYC = `LINK_MAX_CYC,
    parameter int unsigned LINK_LOSS_CYC = `LINK_LOSS_CYC,
    parameter int unsigned LOCK_CYC = `LOCK_CYC,
    parameter int unsigned JAB_CYC = `JAB_CYC,
    parameter int unsigned JAB_HOLD_CYC = `JAB_HOLD_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic auto_negotiation_on,
    input wire logic negotiation_active_bit,
    input wire logic negotiation_link_ok,
    input wire logic link_pulse,
    input wire logic descrambler_locked,
    input wire logic transmit_enable_in,
    input wire logic collision_detect_in,
    input wire phy_link_pkg::reg_req_t reg_req,
    output logic [15:0] rd_data,
    output logic irq,
    output logic collision_indication,
    output logic transmit_pass,
    output logic loopback_enable,
    output logic negotiation_restart,
    output logic link_up
);

    // ----------------------------------------
    // 10 Mbit/s link integrity
    // ----------------------------------------
    phy_link_pkg::link10_state_t link10_state;
    logic [31:0] since_pulse;
    logic [2:0] pulse_run;
    logic gap_ok;
    logic live10;

    assign gap_ok = (since_pulse >= LINK_MIN_CYC) && (since_pulse <= LINK_MAX_CYC);
    assign live10 = (link10_state == phy_link_pkg::LINK_PASS);

    always_ff @(posedge clock) begin
        if (srst) begin
            since_pulse <= 32'h0;
        end else if (link_pulse) begin
            since_pulse <= 32'h1;
        end else if (since_pulse < LINK_LOSS_CYC) begin
            // saturates so a long silence never wraps into a good gap
            since_pulse <= since_pulse + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            link10_state <= phy_link_pkg::LINK_PASS;
            pulse_run <= 3'h0;
        end else begin
            case (link10_state)
                phy_link_pkg::LINK_PASS: begin
                    if (since_pulse >= LINK_LOSS_CYC) begin
                        link10_state <= phy_link_pkg::LINK_FAIL;
                        pulse_run <= 3'h0;
                    end
                end
                phy_link_pkg::LINK_FAIL: begin
                    if (auto_negotiation_on) begin
                        pulse_run <= 3'h0;
                        if (negotiation_link_ok) begin
                            link10_state <= phy_link_pkg::LINK_PASS;
                        end
                    end else if (link_pulse) begin
                        if (!gap_ok) begin
                            // a badly timed pulse starts a fresh run
                            pulse_run <= 3'h1;
                        end else if (pulse_run == (`PULSE_RUN_GOOD - 3'h1)) begin
                            link10_state <= phy_link_pkg::LINK_PASS;
                            pulse_run <= 3'h0;
                        end else begin
                            pulse_run <= pulse_run + 3'h1;
                        end
                    end
                end
                default: begin
                    link10_state <= phy_link_pkg::LINK_FAIL;
                    pulse_run <= 3'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // 100 Mbit/s lock qualification
    // ----------------------------------------
    logic [31:0] lock_count;
    logic live100;

    always_ff @(posedge clock) begin
        if (srst) begin
            lock_count <= 32'h0;
            live100 <= 1'b0;
        end else if (!descrambler_locked) begin
            lock_count <= 32'h0;
            live100 <= 1'b0;
        end else if (lock_count < LOCK_CYC) begin
            lock_count <= lock_count + 32'h1;
            live100 <= (lock_count == LOCK_CYC - 1);
        end
    end

    logic live;
    logic live_prev;

    assign live = speed_100 ? live100 : live10;

    always_ff @(posedge clock) begin
        if (srst) begin
            live_prev <= 1'b1;
            negotiation_restart <= 1'b0;
            link_up <= 1'b1;
        end else begin
            live_prev <= live;
            negotiation_restart <= negotiation_active_bit && live_prev && !live;
            link_up <= live;
        end
    end

    // ----------------------------------------
    // jabber monitor
    // ----------------------------------------
    logic jabber_active;
    logic [31:0] tx_count;
    logic [31:0] hold_count;

    always_ff @(posedge clock) begin
        if (srst) begin
            jabber_active <= 1'b0;
            tx_count <= 32'h0;
            hold_count <= 32'h0;
        end else if (jabber_active) begin
            tx_count <= 32'h0;
            if (transmit_enable_in) begin
                // hold time runs only from the release of transmit enable
                hold_count <= 32'h0;
            end else if (hold_count == JAB_HOLD_CYC - 1) begin
                jabber_active <= 1'b0;
                hold_count <= 32'h0;
            end else begin
                hold_count <= hold_count + 32'h1;
            end
        end else if (transmit_enable_in && !speed_100) begin
            if (tx_count >= JAB_CYC) begin
                jabber_active <= 1'b1;
            end
            tx_count <= tx_count + 32'h1;
        end else begin
            tx_count <= 32'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            collision_indication <= 1'b0;
            transmit_pass <= 1'b0;
            loopback_enable <= 1'b0;
        end else begin
            // collision detection is masked while the jabber forces collision high
            collision_indication <= jabber_active || collision_detect_in;
            transmit_pass <= transmit_enable_in && !jabber_active;
            loopback_enable <= !full_duplex && !jabber_active;
        end
    end

    // ----------------------------------------
    // latched status and register port
    // ----------------------------------------
    logic link_latched;
    logic jabber_latched;
    logic status_read;
    phy_link_pkg::irq_bits_t irq_status;
    phy_link_pkg::irq_bits_t irq_mask;
    phy_link_pkg::irq_bits_t irq_events;
    phy_link_pkg::irq_bits_t irq_w1c;

    assign status_read = reg_req.rd && (reg_req.addr == `STATUS_ADDR);
    assign irq_events.link_lost = live_prev && !live;
    assign irq_events.jabber = jabber_active && !speed_100 && !jabber_latched;
    assign irq_w1c = (reg_req.wr && (reg_req.addr == `IRQ_STAT_ADDR))
        ? {reg_req.wdata[`IRQ_JAB_BIT], reg_req.wdata[`IRQ_LINK_BIT]} : `IRQ_RESET;

    always_ff @(posedge clock) begin
        if (srst) begin
            link_latched <= 1'(`STATUS_RESET >> `STATUS_LINK_BIT);
            jabber_latched <= 1'b0;
        end else if (status_read) begin
            link_latched <= live;
            jabber_latched <= jabber_active && !speed_100;
        end else begin
            // latch low on link loss, latch high on jabber
            link_latched <= link_latched && live;
            jabber_latched <= jabber_latched || (jabber_active && !speed_100);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_data <= 16'h0000;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `STATUS_ADDR: begin
                    rd_data <= 16'h0000;
                    rd_data[`STATUS_LINK_BIT] <= link_latched;
                    rd_data[`STATUS_JAB_BIT] <= jabber_latched && !speed_100;
                end
                `IRQ_STAT_ADDR: rd_data <= {14'h0000, irq_status};
                `IRQ_MASK_ADDR: rd_data <= {14'h0000, irq_mask};
                default: rd_data <= 16'h0000;
            endcase
        end else begin
            rd_data <= 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_status <= `IRQ_RESET;
        end else begin
            // a new event wins over a simultaneous clear
            irq_status <= (irq_status & ~irq_w1c) | irq_events;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_mask <= `IRQ_RESET;
        end else if (reg_req.wr && (reg_req.addr == `IRQ_MASK_ADDR)) begin
            irq_mask <= {reg_req.wdata[`IRQ_JAB_BIT], reg_req.wdata[`IRQ_LINK_BIT]};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    chk_link_loss_drop: assert property (
        live10 && since_pulse >= LINK_LOSS_CYC |=> !live10)
        else $error("link not dropped after pulse loss");

    chk_seven_pulses: assert property (
        !live10 && !auto_negotiation_on && link_pulse && gap_ok && pulse_run == 3'h6 |=> live10)
        else $error("link not restored after seven pulses");

    chk_short_run: assert property (
        !live10 && !auto_negotiation_on && link_pulse && !gap_ok |=> !live10 ##1 pulse_run <= 3'h2)
        else $error("bad pulse did not restart the run");

    chk_lock_time: assert property (
        $rose(live100) |-> $past(descrambler_locked, 1) && lock_count == LOCK_CYC)
        else $error("100M link rose before lock time");

    chk_neg_restart: assert property (
        negotiation_active_bit && live_prev && !live |=> negotiation_restart)
        else $error("negotiation not restarted");

    chk_jab_zero_fast: assert property (
        status_read && speed_100 |=> !rd_data[`STATUS_JAB_BIT])
        else $error("jabber read as 1 at 100M");

    chk_jab_latch_hold: assert property (
        jabber_latched && !status_read |=> jabber_latched)
        else $error("jabber latch lost without a read");

    chk_jab_start: assert property (
        !jabber_active && !speed_100 && transmit_enable_in && tx_count >= JAB_CYC |=> jabber_active)
        else $error("jabber not declared after long transmit");

    chk_jab_gate: assert property (
        jabber_active |=> collision_indication && !transmit_pass && !loopback_enable)
        else $error("jabber did not gate transmit path");

    chk_jab_hold: assert property (
        jabber_active && (transmit_enable_in || hold_count < JAB_HOLD_CYC - 1) |=> jabber_active)
        else $error("jabber released early");

    chk_link_latch: assert property (
        !link_latched && !status_read |=> !link_latched)
        else $error("link latch rose without a read");

    chk_fail_no_early: assert property (
        !live10 && !auto_negotiation_on && !(link_pulse && gap_ok && pulse_run == 3'h6) |=> !live10)
        else $error("link restored before seven pulses");

    chk_lock_drop: assert property (
        !descrambler_locked |=> !live100)
        else $error("100M link kept without lock");

    chk_fast_link_down: assert property (
        speed_100 && !live100 |=> !link_up)
        else $error("100M link shown before lock time");

    chk_restart_gated: assert property (
        !negotiation_active_bit |=> !negotiation_restart)
        else $error("negotiation restarted while not active");

    chk_jab_clear_fast: assert property (
        status_read && speed_100 |=> !jabber_latched)
        else $error("jabber latch reloaded as 1 at 100M");

    chk_jab_latch_set: assert property (
        jabber_active && !speed_100 |=> jabber_latched)
        else $error("jabber not latched");

    chk_jab_no_early: assert property (
        !jabber_active && tx_count < JAB_CYC |=> !jabber_active)
        else $error("jabber declared on a short frame");

    chk_read_reload: assert property (
        status_read |=> link_latched == $past(live))
        else $error("link latch not reloaded by read");

    chk_read_value: assert property (
        status_read |=> rd_data[`STATUS_LINK_BIT] == $past(link_latched))
        else $error("status read did not return the latch");

endmodule : phy_link_and_jabber_monitor

//--- phy_link_and_jabber_monitor_test.sv
// self-checking bench for the link and jabber monitor, with short timing counts
// assumes the package, the design and the partner model are compiled first
`include "phy_link_params.svh"
module phy_link_and_jabber_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned T_MIN = 8, T_MAX = 24, T_LOSS = 100, T_LOCK = 33, T_JAB = 20, T_HOLD = 576;
    logic clock = 1'b0;
    logic auto_negotiation_on = 1'b0;
    logic negotiation_link_ok = 1'b0;
    logic srst = 1'b1;
    logic speed_100 = 1'b0;
    logic full_duplex = 1'b0;
    logic negotiation_active_bit = 1'b1;
    logic transmit_enable_in = 1'b0;
    logic collision_detect_in = 1'b0;
    logic send_on = 1'b0;
    logic lock_on = 1'b0;
    logic [7:0] gap = 8'h10;
    logic link_pulse;
    logic descrambler_locked;
    phy_link_pkg::reg_req_t reg_req = '0;
    logic [15:0] rd_data;
    logic irq, collision_indication, transmit_pass, loopback_enable, negotiation_restart, link_up;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int restarts = 0;
    // {full_duplex, collision in, transmit in, collision out, transmit out, loopback}
    logic [5:0] rows [8] = '{6'h01, 6'h0b, 6'h15, 6'h1f, 6'h20, 6'h2a, 6'h34, 6'h3e};

    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        restarts <= restarts + int'(negotiation_restart);
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    link_partner_model partner_u (.clock(clock), .srst(srst), .send_on(send_on), .gap(gap),
        .lock_on(lock_on), .link_pulse(link_pulse), .descrambler_locked(descrambler_locked));

    phy_link_and_jabber_monitor #(.LINK_MIN_CYC(T_MIN), .LINK_MAX_CYC(T_MAX), .LINK_LOSS_CYC(T_LOSS),
        .LOCK_CYC(T_LOCK), .JAB_CYC(T_JAB), .JAB_HOLD_CYC(T_HOLD)) dut_u (
        .clock(clock), .srst(srst), .speed_100(speed_100), .full_duplex(full_duplex),
        .auto_negotiation_on(auto_negotiation_on), .negotiation_active_bit(negotiation_active_bit),
        .negotiation_link_ok(negotiation_link_ok), .link_pulse(link_pulse),
        .descrambler_locked(descrambler_locked),
        .transmit_enable_in(transmit_enable_in), .collision_detect_in(collision_detect_in),
        .reg_req(reg_req), .rd_data(rd_data), .irq(irq), .collision_indication(collision_indication),
        .transmit_pass(transmit_pass), .loopback_enable(loopback_enable),
        .negotiation_restart(negotiation_restart), .link_up(link_up));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // samples one ns after the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req <= '0;
        #1;
        check(what, rd_data, exp);
    endtask : rd

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        cyc(1);
        check("link after reset", 16'(link_up), 16'h0001);
        check("irq after reset", 16'(irq), 16'h0000);
        rd(`STATUS_ADDR, `STATUS_RESET, "status after reset");
        wr(`IRQ_MASK_ADDR, 16'h0003);
        cyc(80);
        check("link before timeout", 16'(link_up), 16'h0001);
        cyc(30);
        check("link after timeout", 16'(link_up), 16'h0000);
        check("restart pulses", 16'(restarts), 16'h0001);
        check("irq on loss", 16'(irq), 16'h0001);
        rd(`STATUS_ADDR, 16'h0000, "status link down");
        rd(`IRQ_STAT_ADDR, 16'h0001, "irq status");
        wr(`IRQ_MASK_ADDR, 16'h0000);
        cyc(2);
        check("irq masked", 16'(irq), 16'h0000);
        wr(`IRQ_STAT_ADDR, 16'h0001);
        wr(`IRQ_MASK_ADDR, 16'h0003);
        wr(5'h1f, 16'hffff);
        cyc(2);
        check("irq cleared", 16'(irq), 16'h0000);
        rd(5'h1f, 16'h0000, "unmapped read");
        rd(`IRQ_MASK_ADDR, 16'h0003, "mask kept");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            {full_duplex, collision_detect_in, transmit_enable_in} <= rows[i][5:3];
            cyc(2);
            check("row outputs", 16'({collision_indication, transmit_pass, loopback_enable}),
                16'(rows[i][2:0]));
        end
        @(posedge clock);
        full_duplex <= 1'b0;
        collision_detect_in <= 1'b0;
        transmit_enable_in <= 1'b0;
        gap <= 8'h04;
        send_on <= 1'b1;
        cyc(60);
        check("short gaps refused", 16'(link_up), 16'h0000);
        @(posedge clock);
        gap <= 8'h10;
        cyc(70);
        check("too few pulses", 16'(link_up), 16'h0000);
        cyc(80);
        check("seven good pulses", 16'(link_up), 16'h0001);
        rd(`STATUS_ADDR, 16'h0000, "link latched low");
        rd(`STATUS_ADDR, 16'h0004, "link reloaded");
        // negotiation on: loss without restart, pulses ignored, only the engine restores
        @(posedge clock);
        send_on <= 1'b0;
        negotiation_active_bit <= 1'b0;
        auto_negotiation_on <= 1'b1;
        cyc(110);
        check("negotiation_active_bit link lost", 16'(link_up), 16'h0000);
        check("no restart when inactive", 16'(restarts), 16'h0001);
        @(posedge clock);
        send_on <= 1'b1;
        cyc(150);
        check("pulses ignored", 16'(link_up), 16'h0000);
        @(posedge clock);
        negotiation_link_ok <= 1'b1;
        cyc(3);
        check("engine restores", 16'(link_up), 16'h0001);
        @(posedge clock);
        negotiation_link_ok <= 1'b0;
        auto_negotiation_on <= 1'b0;
        negotiation_active_bit <= 1'b1;
        rd(`STATUS_ADDR, 16'h0000, "negotiation_active_bit latch low");
        rd(`IRQ_STAT_ADDR, 16'h0001, "link loss event");
        wr(`IRQ_STAT_ADDR, 16'h0001);
        // jabber: long frame, then hold after the enable drops
        @(posedge clock);
        transmit_enable_in <= 1'b1;
        cyc(15);
        check("short frame passes", 16'(transmit_pass), 16'h0001);
        cyc(10);
        check("jabber outputs", 16'({collision_indication, transmit_pass, loopback_enable}), 16'h0004);
        check("jabber irq", 16'(irq), 16'h0001);
        @(posedge clock);
        transmit_enable_in <= 1'b0;
        cyc(572);
        check("jabber held", 16'(collision_indication), 16'h0001);
        cyc(60);
        check("jabber released", 16'({collision_indication, transmit_pass, loopback_enable}), 16'h0001);
        rd(`STATUS_ADDR, 16'h0006, "jabber latched");
        rd(`STATUS_ADDR, 16'h0004, "jabber reloaded");
        wr(`IRQ_STAT_ADDR, 16'h0002);
        cyc(2);
        check("jabber irq cleared", 16'(irq), 16'h0000);
        // fast mode: lock timing and no jabber on a long frame
        @(posedge clock);
        speed_100 <= 1'b1;
        send_on <= 1'b0;
        cyc(5);
        check("no lock no link", 16'(link_up), 16'h0000);
        @(posedge clock);
        lock_on <= 1'b1;
        transmit_enable_in <= 1'b1;
        cyc(25);
        check("lock too short", 16'(link_up), 16'h0000);
        cyc(20);
        check("lock held", 16'(link_up), 16'h0001);
        check("no jabber fast", 16'({collision_indication, transmit_pass}), 16'h0001);
        rd(`STATUS_ADDR, 16'h0000, "fast status latched");
        rd(`STATUS_ADDR, 16'h0004, "fast status live");
        results();
    end
endmodule : phy_link_and_jabber_monitor_test

//--- phy_link_params.svh
// timing counts, register offsets and field positions for the link and jabber monitor
// assumes a 100 MHz clock; every timing count is derived from a time in microseconds
`ifndef PHY_LINK_PARAMS_SVH
`define PHY_LINK_PARAMS_SVH

`define CLK_MHZ 100
`define LINK_MIN_US 8000
`define LINK_MAX_US 24000
`define LINK_LOSS_US 100000
`define LOCK_US 330
`define JAB_US 20000
`define JAB_HOLD_US 576000
`define LINK_MIN_CYC (`LINK_MIN_US * `CLK_MHZ)
`define LINK_MAX_CYC (`LINK_MAX_US * `CLK_MHZ)
`define LINK_LOSS_CYC (`LINK_LOSS_US * `CLK_MHZ)
`define LOCK_CYC (`LOCK_US * `CLK_MHZ)
`define JAB_CYC (`JAB_US * `CLK_MHZ)
`define JAB_HOLD_CYC (`JAB_HOLD_US * `CLK_MHZ)

`define PULSE_RUN_GOOD 3'h7

`define STATUS_ADDR 5'h01
`define IRQ_STAT_ADDR 5'h10
`define IRQ_MASK_ADDR 5'h11
`define STATUS_LINK_BIT 2
`define STATUS_JAB_BIT 1
`define IRQ_LINK_BIT 0
`define IRQ_JAB_BIT 1
`define STATUS_RESET 16'h0004
`define IRQ_RESET 2'h0

`endif

//--- phy_link_pkg.sv
// types shared by the link and jabber monitor
// assumes nothing beyond a SystemVerilog compiler
package phy_link_pkg;

    typedef enum logic {
        LINK_FAIL = 1'b0,
        LINK_PASS = 1'b1
    } link10_state_t;

    typedef struct packed {
        logic jabber;
        logic link_lost;
    } irq_bits_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : phy_link_pkg
